// *** ucsr_pkg.sv ***
`default_nettype none
package ucsr_pkg;

	typedef logic [7:0]  ucsr_addr_t;
	typedef logic [31:0] ucsr_data_t;

	// register offsets, as seen on the address port
	localparam ucsr_addr_t OFS_PWR_DOWN    = 8'h08;
	localparam ucsr_addr_t OFS_PWR_STATUS  = 8'h09;
	localparam ucsr_addr_t OFS_PORT_SLEEP  = 8'h0A;
	localparam ucsr_addr_t OFS_MOD4_LOAD   = 8'h40;
	localparam ucsr_addr_t OFS_MOD4_WORD   = 8'h41;
	localparam ucsr_addr_t OFS_GAIN        = 8'h42;
	localparam ucsr_addr_t OFS_SAT_THR     = 8'h43;
	localparam ucsr_addr_t OFS_MON_CTRL    = 8'h44;
	localparam ucsr_addr_t OFS_TIMER_LO    = 8'h45;
	localparam ucsr_addr_t OFS_TIMER_HI    = 8'h46;
	localparam ucsr_addr_t OFS_LFSR_TAPS   = 8'h47;
	localparam ucsr_addr_t OFS_CMB_LOAD    = 8'h5C;
	localparam ucsr_addr_t OFS_CMB_WORD    = 8'h5D;
	localparam ucsr_addr_t OFS_CMB_SAT     = 8'h5E;
	localparam ucsr_addr_t OFS_CMB_STRIDE  = 8'h04;
	localparam ucsr_addr_t OFS_GLOBAL_CFG  = 8'h80;

	localparam int NUM_COMBINERS   = 5;
	localparam int NUM_MC_BLOCKS   = 6;
	localparam int NUM_BLOCKS      = 11;

	// field widths and positions
	localparam int MOD4_WORD_W     = 22;
	localparam int GAIN_W          = 9;
	localparam int THR_COUNT_W     = 12;
	localparam int MON_THR_W       = 8;
	localparam int MON_ENABLE_BIT  = 2;
	localparam int MON_DIR_BIT     = 1;
	localparam int MON_RESET_BIT   = 0;
	localparam int TIMER_W         = 48;
	localparam int TAP_W           = 16;
	localparam int LOAD_BIT        = 0;
	localparam int MOD3_WORD_W     = 30;
	localparam int MOD3_LOWRES_W   = 21;
	localparam int CMB_SAT_W       = 9;
	localparam int TOP_SAT_W       = 6;
	localparam int TRAIN_BIT       = 17;
	localparam int IRQ_STYLE_BIT   = 16;
	localparam int SLOT_LSB        = 8;
	localparam int SLOT_W          = 8;
	localparam int READY_SYNC_BIT  = 6;
	localparam int WIDTH_SC_BIT    = 16;
	localparam int WIDTH_MC_BIT    = 15;
	localparam int PARITY_SEL_LSB  = 13;
	localparam int PORT_SLEEP_W    = 19;

	// values after reset
	localparam logic [GAIN_W-1:0]       GAIN_LOW_RST    = 9'h0FF;
	localparam logic [GAIN_W-1:0]       GAIN_HIGH_RST   = 9'h100;
	localparam logic [TAP_W-1:0]        XOR_TAP_RST     = 16'h0500;
	localparam logic [TAP_W-1:0]        SYNC_TAP_RST    = 16'hB400;
	localparam logic [SLOT_W-1:0]       SLOT_RST        = 8'h10;
	localparam logic [NUM_COMBINERS-1:0] MUTE_RST       = 5'h1F;
	localparam logic                    READY_SYNC_RST  = 1'b1;
	localparam logic [PORT_SLEEP_W-1:0] PORT_SLEEP_RST  = 19'h00003;

	// parity output selector codes
	localparam logic [1:0] PAR_SEL_ALL = 2'h0;
	localparam logic [1:0] PAR_SEL_SC  = 2'h1;
	localparam logic [1:0] PAR_SEL_MC  = 2'h2;

	typedef struct packed {
		ucsr_addr_t addr;
		ucsr_data_t wrData;
		logic       wrEn;
		logic       rdEn;
	} ucsr_bus_req_t;

	typedef struct packed {
		logic predistortion;
		logic modulator;
		logic adderQ;
		logic eighthQ;
		logic adderI;
		logic eighthI;
	} ucsr_top_sat_t;

	typedef struct packed {
		logic [MON_THR_W-1:0] sampleA;
		logic [MON_THR_W-1:0] sampleB;
	} ucsr_mon_in_t;

endpackage
`default_nettype wire

// *** ucsr_sticky.sv ***
`timescale 1ns/1ps
`default_nettype none
module ucsr_sticky
	import ucsr_pkg::*;
#(
	parameter int W = 9
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] setVec,
	input  wire logic [W-1:0] clrVec,
	output logic      [W-1:0] flags,
	output logic              newlySet
);

	typedef struct packed {
		logic [W-1:0] flags;
		logic         newly;
	} ucsr_sticky_state_t;

	ucsr_sticky_state_t s_d;
	ucsr_sticky_state_t s_q;

	always_comb begin
		s_d = s_q;
		// a set arriving with its clear must not be lost
		s_d.flags = (s_q.flags & ~clrVec) | setVec;
		s_d.newly = |(setVec & ~s_q.flags);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign flags    = s_q.flags;
	assign newlySet = s_q.newly;

	property p_set_wins;
		@(posedge clk) disable iff (!rst_n)
		(setVec != '0) |=> ((flags & $past(setVec)) == $past(setVec));
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("sticky set lost"); // RULE3

	property p_clear_works;
		@(posedge clk) disable iff (!rst_n)
		(clrVec != '0 && setVec == '0) |=> ((flags & $past(clrVec)) == '0);
	endproperty
	a_clear_works: assert property (p_clear_works) else $error("sticky not cleared"); // RULE14

endmodule
`default_nettype wire

// *** ucsr_regs.sv ***
// Overview of operation
// RULE1 - fourth modulator word is 22 low bits, upper bits zero, resets to zero
// RULE2 - two 9-bit gains, low at bit 0, high at bit 16
// RULE3 - top saturation events stick; any write to that register clears them
// RULE4 - two 12-bit threshold counts read at bits 11:0 and 27:16
// RULE5 - monitor threshold is signed 8-bit value in bits 15:8
// RULE6 - monitor collects only while its enable bit 2 is set
// RULE7 - direction 1 counts samples above threshold, 0 counts below
// RULE8 - writing counter-reset bit gives one reset pulse, bit self-clears
// RULE9 - 48-bit timer read as low word then upper 16 bits
// RULE10 - two 16-bit tap masks: XOR in upper half, SYNC in lower half
// RULE11 - five combiners, each with three registers at base plus index times four
// RULE12 - combiner load bit pulses once, applies third modulator word, self-clears
// RULE13 - third modulator word 30 bits; width bits pick 30 or 21 bits
// RULE14 - combiner saturation flags stick until software writes them
// RULE15 - bit 17 of global config enables input training sequence
// RULE16 - interrupt style 0 reports edge events, 1 reports live levels
// RULE17 - slot counter rollover is 8-bit value; software keeps it at least 16
// RULE18 - bit 6 enables internal ready sync, set after reset
// RULE19 - five mute bits silence combiners and gate clocks, reset to one; code only masks muted combiners' saturation events
// RULE20 - parity select: 00 all ports, 01 single-carrier, 10 multicarrier ports
// RULE21 - power-down bits for eleven blocks override pin defaults once written
// RULE22 - read-only power-on status per block; factory-off blocks stay off
// RULE23 - fourth modulator load bit pulses once, applies word, self-clears
// RULE24 - reserved and spare bits read zero and ignore writes
`timescale 1ns/1ps
`default_nettype none
module ucsr_regs
	import ucsr_pkg::*;
(
	input  wire logic                                  clk,
	input  wire logic                                  rst_n,
	input  wire ucsr_bus_req_t                         busReq,
	output logic [31:0]                                rdData,
	input  wire ucsr_top_sat_t                         topSatEvents,
	input  wire logic [NUM_COMBINERS-1:0][CMB_SAT_W-1:0] cmbSatEvents,
	input  wire ucsr_mon_in_t                          monSamples,
	input  wire logic [NUM_BLOCKS-1:0]                 strapPowerDown,
	input  wire logic [NUM_BLOCKS-1:0]                 factoryPowerOff,
	input  wire logic                                  parityPortA,
	input  wire logic                                  parityPortB,
	input  wire logic                                  parityPortC,
	output logic [MOD4_WORD_W-1:0]                     mod4FreqWord,
	output logic [MOD4_WORD_W-1:0]                     mod4ActiveWord,
	output logic                                       mod4WordLoadStrobe,
	output logic [GAIN_W-1:0]                          gainValueLow,
	output logic [GAIN_W-1:0]                          gainValueHigh,
	output logic                                       monitorCountReset,
	output logic [TAP_W-1:0]                           lfsrXorTaps,
	output logic [TAP_W-1:0]                           lfsrSyncTaps,
	output logic [NUM_COMBINERS-1:0][MOD3_WORD_W-1:0]  mod3ActiveWord,
	output logic [NUM_COMBINERS-1:0]                   mod3WordLoadStrobe,
	output logic                                       singleCarrierWordWidthSel,
	output logic                                       multicarrierWordWidthSel,
	output logic                                       inputTrainingEnable,
	output logic                                       interruptStyleSelect,
	output logic [SLOT_W-1:0]                          slotRollover,
	output logic                                       internalReadySyncEnable,
	output logic [NUM_COMBINERS-1:0]                   combinerMute,
	output logic [NUM_BLOCKS-1:0]                      blockPowerDown,
	output logic [NUM_BLOCKS-1:0]                      blockPowerOnStatus,
	output logic [PORT_SLEEP_W-1:0]                    portSleepControl,
	output logic                                       parityOut,
	output logic                                       satReport
);

	typedef struct packed {
		logic [31:0]                               rdData;
		logic [MOD4_WORD_W-1:0]                    mod4Word;
		logic [MOD4_WORD_W-1:0]                    mod4Active;
		logic                                      mod4Load;
		logic [GAIN_W-1:0]                         gainLow;
		logic [GAIN_W-1:0]                         gainHigh;
		logic [THR_COUNT_W-1:0]                    countA;
		logic [THR_COUNT_W-1:0]                    countB;
		logic [MON_THR_W-1:0]                      monThreshold;
		logic                                      monEnable;
		logic                                      monDirection;
		logic                                      monReset;
		logic [TIMER_W-1:0]                        timer;
		logic [TAP_W-1:0]                          xorTaps;
		logic [TAP_W-1:0]                          syncTaps;
		logic [NUM_COMBINERS-1:0]                  mod3Load;
		logic [NUM_COMBINERS-1:0][MOD3_WORD_W-1:0] mod3Word;
		logic [NUM_COMBINERS-1:0][MOD3_WORD_W-1:0] mod3Active;
		logic                                      trainEnable;
		logic                                      irqStyle;
		logic [SLOT_W-1:0]                         slotRollover;
		logic                                      readySync;
		logic [NUM_COMBINERS-1:0]                  mute;
		logic                                      widthSc;
		logic                                      widthMc;
		logic [1:0]                                paritySel;
		logic [NUM_BLOCKS-1:0]                     powerDown;
		logic                                      pdWritten;
		logic                                      strapTaken;
		logic [NUM_BLOCKS-1:0]                     powerOn;
		logic [PORT_SLEEP_W-1:0]                   portSleep;
		logic                                      parityOut;
		logic                                      satReport;
	} ucsr_regs_state_t;

	localparam logic [THR_COUNT_W-1:0] COUNT_MAX = '1;

	ucsr_regs_state_t                          s_d;
	ucsr_regs_state_t                          s_q;
	logic [TOP_SAT_W-1:0]                      topSet;
	logic [TOP_SAT_W-1:0]                      topClr;
	logic [TOP_SAT_W-1:0]                      topFlags;
	logic                                      topNew;
	logic [NUM_COMBINERS-1:0][CMB_SAT_W-1:0]   cmbSet;
	logic [NUM_COMBINERS-1:0][CMB_SAT_W-1:0]   cmbClr;
	logic [NUM_COMBINERS-1:0][CMB_SAT_W-1:0]   cmbFlags;
	logic [NUM_COMBINERS-1:0]                  cmbNew;
	logic                                      hitA;
	logic                                      hitB;

	assign topSet = topSatEvents;

	// RULE3 top sticky flags
	ucsr_sticky #(.W(TOP_SAT_W)) u_topSticky (
		.clk      (clk),
		.rst_n    (rst_n),
		.setVec   (topSet),
		.clrVec   (topClr),
		.flags    (topFlags),
		.newlySet (topNew)
	);

	for (genvar g = 0; g < NUM_COMBINERS; g++) begin : gCmb
		// RULE19 muted combiner raises nothing
		assign cmbSet[g] = cmbSatEvents[g] & {CMB_SAT_W{~s_q.mute[g]}};
		// RULE14 combiner sticky flags
		ucsr_sticky #(.W(CMB_SAT_W)) u_cmbSticky (
			.clk      (clk),
			.rst_n    (rst_n),
			.setVec   (cmbSet[g]),
			.clrVec   (cmbClr[g]),
			.flags    (cmbFlags[g]),
			.newlySet (cmbNew[g])
		);
	end

	// RULE5 signed compare, RULE7 direction picks above or below
	always_comb begin
		hitA = s_q.monDirection ? ($signed(monSamples.sampleA) > $signed(s_q.monThreshold))
		                        : ($signed(monSamples.sampleA) < $signed(s_q.monThreshold));
		hitB = s_q.monDirection ? ($signed(monSamples.sampleB) > $signed(s_q.monThreshold))
		                        : ($signed(monSamples.sampleB) < $signed(s_q.monThreshold));
	end

	always_comb begin
		ucsr_addr_t cmbBase;
		logic [31:0] rdMux;
		cmbBase = '0;
		rdMux = '0;
		s_d = s_q;
		topClr = '0;
		cmbClr = '0;
		s_d.rdData = '0;
		// RULE8 RULE12 RULE23 load and reset bits live one cycle only
		s_d.mod4Load = 1'b0;
		s_d.monReset = 1'b0;
		s_d.mod3Load = '0;

		// RULE21 pin defaults taken once after release, unless already written
		if (!s_q.strapTaken) begin
			s_d.strapTaken = 1'b1;
			if (!s_q.pdWritten) begin
				s_d.powerDown = strapPowerDown;
			end
		end

		if (busReq.wrEn) begin
			case (busReq.addr)
				OFS_PWR_DOWN: begin
					// RULE13 width selects, RULE20 parity select, RULE21 power-down
					s_d.widthSc = busReq.wrData[WIDTH_SC_BIT];
					s_d.widthMc = busReq.wrData[WIDTH_MC_BIT];
					s_d.paritySel = busReq.wrData[PARITY_SEL_LSB +: 2];
					s_d.powerDown = busReq.wrData[NUM_BLOCKS-1:0];
					s_d.pdWritten = 1'b1;
				end
				OFS_PORT_SLEEP: s_d.portSleep = busReq.wrData[PORT_SLEEP_W-1:0];
				// RULE23 fourth modulator load
				OFS_MOD4_LOAD: s_d.mod4Load = busReq.wrData[LOAD_BIT];
				// RULE1 fourth modulator word
				OFS_MOD4_WORD: s_d.mod4Word = busReq.wrData[MOD4_WORD_W-1:0];
				OFS_GAIN: begin
					// RULE2 gain pair
					s_d.gainLow = busReq.wrData[GAIN_W-1:0];
					s_d.gainHigh = busReq.wrData[16 +: GAIN_W];
				end
				// RULE3 any write clears top flags
				OFS_SAT_THR: topClr = '1;
				OFS_MON_CTRL: begin
					s_d.monThreshold = busReq.wrData[SLOT_LSB +: MON_THR_W];
					s_d.monEnable = busReq.wrData[MON_ENABLE_BIT];
					s_d.monDirection = busReq.wrData[MON_DIR_BIT];
					// RULE8 counter reset request
					s_d.monReset = busReq.wrData[MON_RESET_BIT];
				end
				OFS_LFSR_TAPS: begin
					// RULE10 tap masks
					s_d.xorTaps = busReq.wrData[31:16];
					s_d.syncTaps = busReq.wrData[TAP_W-1:0];
				end
				OFS_GLOBAL_CFG: begin
					// RULE15 RULE16 RULE17 RULE18 RULE19 global config fields
					s_d.trainEnable = busReq.wrData[TRAIN_BIT];
					s_d.irqStyle = busReq.wrData[IRQ_STYLE_BIT];
					s_d.slotRollover = busReq.wrData[SLOT_LSB +: SLOT_W];
					s_d.readySync = busReq.wrData[READY_SYNC_BIT];
					s_d.mute = busReq.wrData[NUM_COMBINERS-1:0];
				end
				default: ;
			endcase
		end

		// RULE11 combiner register sets at base plus (index + 1) times four, index counted from 0
		for (int i = 0; i < NUM_COMBINERS; i++) begin
			cmbBase = OFS_CMB_LOAD + 8'((i + 1) * 4);
			if (busReq.wrEn && busReq.addr == cmbBase) begin
				s_d.mod3Load[i] = busReq.wrData[LOAD_BIT];
			end
			if (busReq.wrEn && busReq.addr == cmbBase + 8'h01) begin
				s_d.mod3Word[i] = busReq.wrData[MOD3_WORD_W-1:0];
			end
			// RULE14 written ones clear combiner flags
			if (busReq.wrEn && busReq.addr == cmbBase + 8'h02) begin
				cmbClr[i] = busReq.wrData[CMB_SAT_W-1:0];
			end
			// RULE12 RULE13 strobe puts the word into use at chosen width
			if (s_q.mod3Load[i]) begin
				s_d.mod3Active[i] = s_q.mod3Word[i];
				if (!s_q.widthSc) begin
					s_d.mod3Active[i][MOD3_WORD_W-MOD3_LOWRES_W-1:0] = '0;
				end
			end
			if (busReq.rdEn && busReq.addr == cmbBase + 8'h01) begin
				rdMux = {2'b00, s_q.mod3Word[i]};
			end
			if (busReq.rdEn && busReq.addr == cmbBase + 8'h02) begin
				rdMux = {23'h0, cmbFlags[i]};
			end
		end

		// RULE23 strobe applies the fourth modulator word
		if (s_q.mod4Load) begin
			s_d.mod4Active = s_q.mod4Word;
		end

		// RULE6 collect only when enabled; RULE8 reset pulse wins
		if (s_q.monReset) begin
			s_d.countA = '0;
			s_d.countB = '0;
			s_d.timer = '0;
		end else if (s_q.monEnable) begin
			s_d.timer = s_q.timer + 48'h1;
			// counts saturate rather than wrap so a long run never reads small
			if (hitA && s_q.countA != COUNT_MAX) begin
				s_d.countA = s_q.countA + 12'h1;
			end
			if (hitB && s_q.countB != COUNT_MAX) begin
				s_d.countB = s_q.countB + 12'h1;
			end
		end

		// RULE22 power-on status, factory-off blocks never report on
		s_d.powerOn = ~s_q.powerDown & ~factoryPowerOff;

		// RULE20 parity output select, unused code gives zero
		case (s_q.paritySel)
			PAR_SEL_ALL: s_d.parityOut = parityPortA | parityPortB | parityPortC;
			PAR_SEL_SC:  s_d.parityOut = parityPortA;
			PAR_SEL_MC:  s_d.parityOut = parityPortB | parityPortC;
			default:     s_d.parityOut = 1'b0;
		endcase

		// RULE16 edge events or live levels
		if (s_q.irqStyle) begin
			s_d.satReport = (|topSet) | (|cmbSet);
		end else begin
			s_d.satReport = topNew | (|cmbNew);
		end

		// RULE24 reserved bits and unmapped addresses read zero
		if (busReq.rdEn) begin
			case (busReq.addr)
				OFS_PWR_DOWN:   rdMux = {15'h0, s_q.widthSc, s_q.widthMc, s_q.paritySel,
				                         2'b00, s_q.powerDown};
				OFS_PWR_STATUS: rdMux = {21'h0, s_q.powerOn};
				OFS_PORT_SLEEP: rdMux = {13'h0, s_q.portSleep};
				OFS_MOD4_WORD:  rdMux = {10'h0, s_q.mod4Word};
				OFS_GAIN:       rdMux = {7'h0, s_q.gainHigh, 7'h0, s_q.gainLow};
				// RULE4 threshold counts beside the flags
				OFS_SAT_THR:    rdMux = {topFlags[5:2], s_q.countB, 2'b00, topFlags[1:0],
				                         s_q.countA};
				OFS_MON_CTRL:   rdMux = {16'h0, s_q.monThreshold, 5'h0, s_q.monEnable,
				                         s_q.monDirection, 1'b0};
				// RULE9 timer split over two words
				OFS_TIMER_LO:   rdMux = s_q.timer[31:0];
				OFS_TIMER_HI:   rdMux = {16'h0, s_q.timer[TIMER_W-1:32]};
				OFS_LFSR_TAPS:  rdMux = {s_q.xorTaps, s_q.syncTaps};
				OFS_GLOBAL_CFG: rdMux = {14'h0, s_q.trainEnable, s_q.irqStyle, s_q.slotRollover,
				                         1'b0, s_q.readySync, 1'b0, s_q.mute};
				default: ;
			endcase
			s_d.rdData = rdMux;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.gainLow <= GAIN_LOW_RST;
			s_q.gainHigh <= GAIN_HIGH_RST;
			s_q.xorTaps <= XOR_TAP_RST;
			s_q.syncTaps <= SYNC_TAP_RST;
			s_q.slotRollover <= SLOT_RST;
			s_q.readySync <= READY_SYNC_RST;
			s_q.mute <= MUTE_RST;
			s_q.portSleep <= PORT_SLEEP_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdData                    = s_q.rdData;
	assign mod4FreqWord              = s_q.mod4Word;
	assign mod4ActiveWord            = s_q.mod4Active;
	assign mod4WordLoadStrobe        = s_q.mod4Load;
	assign gainValueLow              = s_q.gainLow;
	assign gainValueHigh             = s_q.gainHigh;
	assign monitorCountReset         = s_q.monReset;
	assign lfsrXorTaps               = s_q.xorTaps;
	assign lfsrSyncTaps              = s_q.syncTaps;
	assign mod3ActiveWord            = s_q.mod3Active;
	assign mod3WordLoadStrobe        = s_q.mod3Load;
	assign singleCarrierWordWidthSel = s_q.widthSc;
	assign multicarrierWordWidthSel  = s_q.widthMc;
	assign inputTrainingEnable       = s_q.trainEnable;
	assign interruptStyleSelect      = s_q.irqStyle;
	assign slotRollover              = s_q.slotRollover;
	assign internalReadySyncEnable   = s_q.readySync;
	assign combinerMute              = s_q.mute;
	assign blockPowerDown            = s_q.powerDown;
	assign blockPowerOnStatus        = s_q.powerOn;
	assign portSleepControl          = s_q.portSleep;
	assign parityOut                 = s_q.parityOut;
	assign satReport                 = s_q.satReport;

	property p_mod4_pulse;
		@(posedge clk) disable iff (!rst_n)
		(busReq.wrEn && busReq.addr == OFS_MOD4_LOAD && busReq.wrData[LOAD_BIT])
		|=> mod4WordLoadStrobe ##1 (mod4ActiveWord == $past(mod4FreqWord));
	endproperty
	a_mod4_pulse: assert property (p_mod4_pulse) else $error("mod4 load not applied"); // RULE23

	property p_mon_reset;
		@(posedge clk) disable iff (!rst_n)
		(busReq.wrEn && busReq.addr == OFS_MON_CTRL && busReq.wrData[MON_RESET_BIT])
		|=> monitorCountReset ##1 (s_q.timer == '0 && s_q.countA == '0);
	endproperty
	a_mon_reset: assert property (p_mon_reset) else $error("monitor reset missing"); // RULE8

	property p_mod3_pulse;
		@(posedge clk) disable iff (!rst_n)
		(busReq.wrEn && busReq.addr == OFS_CMB_LOAD + OFS_CMB_STRIDE && busReq.wrData[LOAD_BIT])
		|=> mod3WordLoadStrobe[0] ##1 !mod3WordLoadStrobe[0];
	endproperty
	a_mod3_pulse: assert property (p_mod3_pulse) else $error("mod3 load not a pulse"); // RULE12

	property p_count_above;
		@(posedge clk) disable iff (!rst_n)
		(s_q.monEnable && !s_q.monReset && s_q.monDirection && s_q.countA != COUNT_MAX
		 && $signed(monSamples.sampleA) > $signed(s_q.monThreshold))
		|=> (s_q.countA == $past(s_q.countA) + 12'h1);
	endproperty
	a_count_above: assert property (p_count_above) else $error("above count missed"); // RULE7

	property p_idle_timer;
		@(posedge clk) disable iff (!rst_n)
		(!s_q.monEnable && !s_q.monReset) |=> $stable(s_q.timer);
	endproperty
	a_idle_timer: assert property (p_idle_timer) else $error("timer ran while off"); // RULE6

	property p_unmapped_zero;
		@(posedge clk) disable iff (!rst_n)
		(busReq.rdEn && busReq.addr == 8'h00) |=> (rdData == 32'h0);
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read nonzero"); // RULE24

	property p_mute_write;
		@(posedge clk) disable iff (!rst_n)
		(busReq.wrEn && busReq.addr == OFS_GLOBAL_CFG)
		|=> (combinerMute == $past(busReq.wrData[NUM_COMBINERS-1:0]));
	endproperty
	a_mute_write: assert property (p_mute_write) else $error("mute not written"); // RULE19

	property p_parity_all;
		@(posedge clk) disable iff (!rst_n)
		(s_q.paritySel == PAR_SEL_ALL)
		|=> (parityOut == ($past(parityPortA) | $past(parityPortB) | $past(parityPortC)));
	endproperty
	a_parity_all: assert property (p_parity_all) else $error("parity select wrong"); // RULE20

	property p_pd_override;
		@(posedge clk) disable iff (!rst_n)
		(busReq.wrEn && busReq.addr == OFS_PWR_DOWN)
		|=> (blockPowerDown == $past(busReq.wrData[NUM_BLOCKS-1:0]))
		##1 ((blockPowerOnStatus & $past(factoryPowerOff)) == '0);
	endproperty
	a_pd_override: assert property (p_pd_override) else $error("power-down override lost"); // RULE21

endmodule
`default_nettype wire

// *** test_upconverter_control_status_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checkCount++; if ((s) !== (e)) begin numErrors++; \
	$display("Error %s expected %h seen %h", n, e, s); end end
module test_upconverter_control_status_regs
	import ucsr_pkg::*;
;
	logic                                      clk = 1'b0;
	logic                                      rst_n = 1'b0;
	ucsr_bus_req_t                             busReq = '0;
	ucsr_top_sat_t                             topSatEvents = '0;
	logic [NUM_COMBINERS-1:0][CMB_SAT_W-1:0]   cmbSatEvents = '0;
	ucsr_mon_in_t                              monSamples = '{8'h05, 8'hFB};
	logic [NUM_BLOCKS-1:0]                     strapPowerDown = 11'h0F0;
	logic [NUM_BLOCKS-1:0]                     factoryPowerOff = 11'h001;
	logic                                      parityPortA = 1'b1;
	logic                                      parityPortB = 1'b0;
	logic                                      parityPortC = 1'b0;
	logic [31:0]                               rdData;
	logic [NUM_BLOCKS-1:0]                     blockPowerDown, blockPowerOnStatus;
	logic [GAIN_W-1:0]                         gainValueLow, gainValueHigh;
	logic [MOD4_WORD_W-1:0]                    mod4ActiveWord;
	logic [NUM_COMBINERS-1:0][MOD3_WORD_W-1:0] mod3ActiveWord;
	logic [NUM_COMBINERS-1:0]                  mod3WordLoadStrobe, combinerMute;
	logic                                      mod4WordLoadStrobe, monitorCountReset, parityOut;
	logic                                      singleCarrierWordWidthSel, satReport;
	logic                                      inputTrainingEnable, interruptStyleSelect;
	int                                        numErrors = 0;
	int                                        checkCount = 0;
	ucsr_addr_t                                a;

	ucsr_regs uut (
		.clk, .rst_n, .busReq, .rdData, .topSatEvents, .cmbSatEvents, .monSamples,
		.strapPowerDown, .factoryPowerOff, .parityPortA, .parityPortB, .parityPortC,
		.mod4ActiveWord, .mod4WordLoadStrobe, .gainValueLow, .gainValueHigh, .monitorCountReset,
		.mod3ActiveWord, .mod3WordLoadStrobe, .singleCarrierWordWidthSel, .inputTrainingEnable,
		.interruptStyleSelect, .combinerMute, .blockPowerDown, .blockPowerOnStatus, .parityOut,
		.satReport, .mod4FreqWord(), .lfsrXorTaps(), .lfsrSyncTaps(),
		.multicarrierWordWidthSel(), .slotRollover(), .internalReadySyncEnable(),
		.portSleepControl()
	);

	always #5 clk = ~clk;

	// one request per call with an idle edge after it, so no edge sees two assignments
	task automatic bus(input ucsr_addr_t ad, input ucsr_data_t d, input logic w);
		@(posedge clk);
		busReq <= '{ad, d, w, !w};
		@(posedge clk);
		busReq <= '0;
		#1;
	endtask
	task automatic wr(input ucsr_addr_t ad, input ucsr_data_t d);
		bus(ad, d, 1'b1);
	endtask
	task automatic rd(input ucsr_addr_t ad, input ucsr_data_t e);
		bus(ad, 32'h0, 1'b0);
		`CHK($sformatf("read %h", ad), e, rdData)
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checkCount, numErrors);
		if (numErrors == 0 && checkCount > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		#20000;
		numErrors++;
		end_of_test();
	end

	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		rd(OFS_MOD4_WORD, 32'h0);
		rd(OFS_GAIN, 32'h010000FF);
		rd(OFS_LFSR_TAPS, 32'h0500B400);
		rd(OFS_GLOBAL_CFG, 32'h0000105F);
		rd(OFS_PWR_DOWN, 32'h000000F0);
		rd(8'h00, 32'h0);
		wr(OFS_MOD4_WORD, 32'hFFFFFFFF);
		rd(OFS_MOD4_WORD, 32'h003FFFFF);
		wr(OFS_MOD4_LOAD, 32'h1);
		`CHK("mod4 strobe", 1'b1, mod4WordLoadStrobe)
		@(posedge clk);
		#1;
		`CHK("mod4 word", 22'h3FFFFF, mod4ActiveWord)
		rd(OFS_MOD4_LOAD, 32'h0);
		wr(OFS_GAIN, 32'hFFFFFFFF);
		`CHK("gains", 18'h3FFFF, {gainValueHigh, gainValueLow})
		rd(OFS_GAIN, 32'h01FF01FF);
		@(posedge clk);
		topSatEvents <= 6'h20;
		@(posedge clk);
		topSatEvents <= '0;
		@(posedge clk);
		#1;
		`CHK("sat pulse", 1'b1, satReport)
		rd(OFS_SAT_THR, 32'h80000000);
		wr(OFS_SAT_THR, 32'h0);
		rd(OFS_SAT_THR, 32'h0);
		$display("registers and flags done");
		// threshold -2: sample A (+5) is above it, sample B (-5) below
		for (int d = 0; d < 2; d++) begin
			wr(OFS_MON_CTRL, 32'h1);
			`CHK("count reset", 1'b1, monitorCountReset)
			wr(OFS_MON_CTRL, 32'h0000FE04 | 32'(d << 1));
			repeat (8) @(posedge clk);
			wr(OFS_MON_CTRL, 32'h0);
			rd(OFS_SAT_THR, d ? 32'h0000000A : 32'h000A0000);
			rd(OFS_TIMER_LO, 32'hA);
			rd(OFS_TIMER_HI, 32'h0);
		end
		rd(OFS_MON_CTRL, 32'h0);
		$display("monitor done");
		wr(OFS_GLOBAL_CFG, 32'h00031040);
		`CHK("mute", 5'h00, combinerMute)
		`CHK("train style", 2'b11, {inputTrainingEnable, interruptStyleSelect})
		for (int n = 1; n <= NUM_COMBINERS; n++) begin
			a = ucsr_addr_t'(n * 4);
			wr(OFS_CMB_WORD + a, 32'hFFFFFFFF);
			rd(OFS_CMB_WORD + a, 32'h3FFFFFFF);
			wr(OFS_CMB_LOAD + a, 32'h1);
			`CHK("mod3 strobe", 5'(1 << (n - 1)), mod3WordLoadStrobe)
			@(posedge clk);
			#1;
			`CHK("mod3 word", 30'h3FFFFE00, mod3ActiveWord[n-1])
			@(posedge clk);
			cmbSatEvents[n-1] <= 9'h1FF;
			@(posedge clk);
			cmbSatEvents <= '0;
			#1;
			`CHK("sat level", 1'b1, satReport)
			rd(OFS_CMB_SAT + a, 32'h1FF);
			wr(OFS_CMB_SAT + a, 32'h100);
			rd(OFS_CMB_SAT + a, 32'h0FF);
		end
		$display("combiners done");
		wr(OFS_PWR_DOWN, 32'h00010005);
		`CHK("power down", 11'h005, blockPowerDown)
		`CHK("width", 1'b1, singleCarrierWordWidthSel)
		rd(OFS_PWR_STATUS, 32'h000007FA);
		`CHK("power on", 11'h7FA, blockPowerOnStatus)
		for (int s = 0; s < 4; s++) begin
			wr(OFS_PWR_DOWN, 32'h5 | 32'(s << 13));
			@(posedge clk);
			#1;
			`CHK("parity", s < 2, parityOut)
		end
		$display("power and parity done");
		end_of_test();
	end
endmodule
`default_nettype wire
